// *** mpio_ports.v ***
// six parallel ports behind an apb slave
`timescale 1ns/10ps
`include "mpio_consts.vh"
module mpio_ports (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] p1_i,
  output wire [7:0] p1_o,
  output wire [7:0] p1_oe,
  input wire [2:0] p2_i,
  output wire [2:0] p2_o,
  output wire [2:0] p2_oe,
  input wire [3:0] p3_i,
  output wire [3:0] p3_o,
  output wire [3:0] p3_oe,
  input wire [7:0] p5_i,
  output wire [7:0] p5_o,
  output wire [7:0] p5_oe,
  input wire [7:0] p6_i,
  output wire [7:0] p6_o,
  output wire [7:0] p6_oe,
  input wire [7:0] p7_i,
  output wire [7:0] p7_o,
  output wire [7:0] p7_oe,
  input wire [7:0] seg1_val,
  input wire [7:0] seg5_val,
  input wire [7:0] seg7_val,
  output reg [7:0] p6_analog_en,
  output reg crystal_mode,
  output reg p20_irq
);
  reg [7:0] p1_lat_q;
  reg [7:0] p1_seg_q;
  reg [2:0] p2_lat_q;
  reg [3:0] p3_lat_q;
  reg [3:0] p3_drv_q;
  reg [7:0] p5_lat_q;
  reg [7:0] p5_seg_q;
  reg [7:0] p6_dir_q;
  reg [7:0] p6_lat_q;
  reg [7:0] p7_lat_q;
  reg [7:0] p7_seg_q;
  reg global_output_enable_q;
  reg dual_q;
  reg stop_q;
  reg analog_input_disable_q;
  reg p20_prev_q;
  reg [31:0] rd_d;
  reg err_d;
  wire setup = psel & ~penable;
  wire wr_acc = psel & penable & pready & pwrite;
  wire [7:0] wd = pwdata[7:0];
  // no wait state: data sampled in setup, answered in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h00000000 : rd_d;
        pslverr <= err_d;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end
  wire [7:0] p6_analog = ~p6_dir_q & ~p6_lat_q & {8{~analog_input_disable_q}};
  always @* begin
    rd_d = 32'h00000000;
    err_d = 1'b0;
    case (paddr)
      `MPIO_OFF_P1_LAT: rd_d[7:0] = p1_lat_q;
      `MPIO_OFF_P1_SEG: rd_d[7:0] = p1_seg_q;
      `MPIO_OFF_P1_PIN: rd_d[7:0] = p1_i;
      `MPIO_OFF_P2_LAT: rd_d[2:0] = p2_lat_q;
      `MPIO_OFF_P2_PIN: rd_d[2:0] = p2_i;
      `MPIO_OFF_P3_LAT: rd_d[3:0] = p3_lat_q;
      `MPIO_OFF_P3_DRV: rd_d[3:0] = p3_drv_q;
      `MPIO_OFF_P3_PIN: rd_d[3:0] = p3_i;
      `MPIO_OFF_P5_LAT: rd_d[7:0] = p5_lat_q;
      `MPIO_OFF_P5_SEG: rd_d[7:0] = p5_seg_q;
      `MPIO_OFF_P5_PIN: rd_d[7:0] = p5_i;
      `MPIO_OFF_P6_DIR: rd_d[7:0] = p6_dir_q;
      `MPIO_OFF_P6_LAT: rd_d[7:0] = p6_lat_q;
      `MPIO_OFF_P6_PIN: rd_d[7:0] = p6_i & ~p6_analog;
      `MPIO_OFF_P7_LAT: rd_d[7:0] = p7_lat_q;
      `MPIO_OFF_P7_SEG: rd_d[7:0] = p7_seg_q;
      `MPIO_OFF_P7_PIN: rd_d[7:0] = p7_i;
      `MPIO_OFF_CTRL: begin
        rd_d[`MPIO_CTRL_GLOBAL_OUTPUT_ENABLE_BIT] = global_output_enable_q;
        rd_d[`MPIO_CTRL_DUAL_BIT] = dual_q;
        rd_d[`MPIO_CTRL_STOP_BIT] = stop_q;
        rd_d[`MPIO_CTRL_ANALOG_INPUT_DISABLE_BIT] = analog_input_disable_q;
        rd_d[`MPIO_CTRL_P20IRQ_BIT] = p20_irq;
      end
      default: err_d = 1'b1;
    endcase
  end
  // register writes; pin registers have no write path
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p1_lat_q <= `MPIO_RST_LAT8;
      p1_seg_q <= `MPIO_RST_ZERO8;
      p2_lat_q <= `MPIO_RST_LAT3;
      p3_lat_q <= `MPIO_RST_LAT4;
      p3_drv_q <= 4'h0;
      p5_lat_q <= `MPIO_RST_LAT8;
      p5_seg_q <= `MPIO_RST_ZERO8;
      p6_dir_q <= `MPIO_RST_ZERO8;
      p6_lat_q <= `MPIO_RST_ZERO8;
      p7_lat_q <= `MPIO_RST_LAT8;
      p7_seg_q <= `MPIO_RST_ZERO8;
      global_output_enable_q <= 1'b1;
      dual_q <= 1'b0;
      stop_q <= 1'b0;
      analog_input_disable_q <= 1'b1;
    end else if (wr_acc) begin
      case (paddr)
        `MPIO_OFF_P1_LAT: p1_lat_q <= wd;
        `MPIO_OFF_P1_SEG: p1_seg_q <= wd;
        `MPIO_OFF_P2_LAT: p2_lat_q <= wd[2:0];
        `MPIO_OFF_P3_LAT: p3_lat_q <= wd[3:0];
        `MPIO_OFF_P3_DRV: p3_drv_q <= wd[3:0];
        `MPIO_OFF_P5_LAT: p5_lat_q <= wd;
        `MPIO_OFF_P5_SEG: p5_seg_q <= wd;
        `MPIO_OFF_P6_DIR: p6_dir_q <= wd;
        `MPIO_OFF_P6_LAT: p6_lat_q <= wd;
        `MPIO_OFF_P7_LAT: p7_lat_q <= wd;
        `MPIO_OFF_P7_SEG: p7_seg_q <= wd;
        `MPIO_OFF_CTRL: begin
          global_output_enable_q <= pwdata[`MPIO_CTRL_GLOBAL_OUTPUT_ENABLE_BIT];
          dual_q <= pwdata[`MPIO_CTRL_DUAL_BIT];
          stop_q <= pwdata[`MPIO_CTRL_STOP_BIT];
          analog_input_disable_q <= pwdata[`MPIO_CTRL_ANALOG_INPUT_DISABLE_BIT];
        end
        default: ;
      endcase
    end
  end
  // port two pin zero interrupt latch; set wins over clear
  // open drain pin: released reads high on the pull-up, driven means low
  wire p20_fall = p20_prev_q & p2_oe[0];
  wire irq_clr = wr_acc & (paddr == `MPIO_OFF_CTRL) & pwdata[`MPIO_CTRL_P20IRQ_BIT];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p20_prev_q <= 1'b1;
      p20_irq <= 1'b0;
      p6_analog_en <= 8'h00;
      crystal_mode <= 1'b0;
    end else begin
      p20_prev_q <= ~p2_oe[0];
      if (p20_fall) begin
        p20_irq <= 1'b1;
      end else if (irq_clr) begin
        p20_irq <= 1'b0;
      end
      p6_analog_en <= p6_analog;
      crystal_mode <= dual_q;
    end
  end
  wire [2:0] p2_allow;
  assign p2_allow[0] = global_output_enable_q & ~stop_q;
  assign p2_allow[1] = global_output_enable_q & ~dual_q;
  assign p2_allow[2] = global_output_enable_q & ~dual_q;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g8
      mpio_pin_cell u_p1 (.pclk(pclk), .presetn(presetn), .latch(p1_lat_q[gi]),
        .seg_sel(p1_seg_q[gi]), .seg_val(seg1_val[gi]), .push_pull(1'b0),
        .drive_allowed(global_output_enable_q), .pin_o(p1_o[gi]), .pin_oe(p1_oe[gi]));
      mpio_pin_cell u_p5 (.pclk(pclk), .presetn(presetn), .latch(p5_lat_q[gi]),
        .seg_sel(p5_seg_q[gi]), .seg_val(seg5_val[gi]), .push_pull(1'b0),
        .drive_allowed(global_output_enable_q), .pin_o(p5_o[gi]), .pin_oe(p5_oe[gi]));
      mpio_pin_cell u_p7 (.pclk(pclk), .presetn(presetn), .latch(p7_lat_q[gi]),
        .seg_sel(p7_seg_q[gi]), .seg_val(seg7_val[gi]), .push_pull(1'b0),
        .drive_allowed(global_output_enable_q), .pin_o(p7_o[gi]), .pin_oe(p7_oe[gi]));
      mpio_pin_cell u_p6 (.pclk(pclk), .presetn(presetn), .latch(p6_lat_q[gi]),
        .seg_sel(1'b0), .seg_val(1'b0), .push_pull(1'b1),
        .drive_allowed(global_output_enable_q & p6_dir_q[gi]),
        .pin_o(p6_o[gi]), .pin_oe(p6_oe[gi]));
    end
    for (gi = 0; gi < 4; gi = gi + 1) begin : g4
      mpio_pin_cell u_p3 (.pclk(pclk), .presetn(presetn), .latch(p3_lat_q[gi]),
        .seg_sel(1'b0), .seg_val(1'b0), .push_pull(p3_drv_q[gi]),
        .drive_allowed(global_output_enable_q), .pin_o(p3_o[gi]), .pin_oe(p3_oe[gi]));
    end
    for (gi = 0; gi < 3; gi = gi + 1) begin : g3
      mpio_pin_cell u_p2 (.pclk(pclk), .presetn(presetn), .latch(p2_lat_q[gi]),
        .seg_sel(1'b0), .seg_val(1'b0), .push_pull(1'b0),
        .drive_allowed(p2_allow[gi]), .pin_o(p2_o[gi]), .pin_oe(p2_oe[gi]));
    end
  endgenerate
endmodule // mpio_ports

// *** mpio_consts.vh ***
// register offsets, control bit positions and reset values of the parallel port block
`ifndef MPIO_CONSTS_VH
`define MPIO_CONSTS_VH
`define MPIO_OFF_P1_LAT 12'h000
`define MPIO_OFF_P1_SEG 12'h004
`define MPIO_OFF_P1_PIN 12'h008
`define MPIO_OFF_P2_LAT 12'h00c
`define MPIO_OFF_P2_PIN 12'h010
`define MPIO_OFF_P3_LAT 12'h014
`define MPIO_OFF_P3_DRV 12'h018
`define MPIO_OFF_P3_PIN 12'h01c
`define MPIO_OFF_P5_LAT 12'h020
`define MPIO_OFF_P5_SEG 12'h024
`define MPIO_OFF_P5_PIN 12'h028
`define MPIO_OFF_P6_DIR 12'h02c
`define MPIO_OFF_P6_LAT 12'h030
`define MPIO_OFF_P6_PIN 12'h034
`define MPIO_OFF_P7_LAT 12'h038
`define MPIO_OFF_P7_SEG 12'h03c
`define MPIO_OFF_P7_PIN 12'h040
`define MPIO_OFF_CTRL 12'h044
`define MPIO_CTRL_GLOBAL_OUTPUT_ENABLE_BIT 0
`define MPIO_CTRL_DUAL_BIT 1
`define MPIO_CTRL_STOP_BIT 2
`define MPIO_CTRL_ANALOG_INPUT_DISABLE_BIT 3
`define MPIO_CTRL_P20IRQ_BIT 8
`define MPIO_RST_LAT8 8'hff
`define MPIO_RST_LAT3 3'h7
`define MPIO_RST_LAT4 4'hf
`define MPIO_RST_ZERO8 8'h00
`define MPIO_RST_CTRL 4'h9
`endif

// *** mpio_pin_cell.v ***
// one pin cell: output enable and level from latch, segment and driver type
`timescale 1ns/10ps
module mpio_pin_cell (
  input wire pclk,
  input wire presetn,
  input wire latch,
  input wire seg_sel,
  input wire seg_val,
  input wire push_pull,
  input wire drive_allowed,
  output reg pin_o,
  output reg pin_oe
);
  reg o_d;
  reg oe_d;
  always @* begin
    o_d = latch;
    oe_d = 1'b0;
    if (!drive_allowed) begin
      oe_d = 1'b0;
    end else if (seg_sel) begin
      o_d = seg_val;
      oe_d = 1'b1;
    end else if (push_pull) begin
      oe_d = 1'b1;
    end else begin
      o_d = 1'b0;
      oe_d = ~latch;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_o <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_o <= o_d;
      pin_oe <= oe_d;
    end
  end
endmodule // mpio_pin_cell

// *** mpio_board.sv ***
// board model: pull-ups and optional low drivers on the pins of one port
`timescale 1ns/10ps
module mpio_board #(parameter int W = 8) (
  input wire logic [W-1:0] d,
  input wire logic [W-1:0] e,
  input wire logic [W-1:0] lo,
  output logic [W-1:0] v
);
  // released pins rise to the pull-up unless the board holds them low
  assign v = (e & d) | (~e & ~lo);
endmodule // mpio_board

// *** mpio_props.sv ***
// assertions on the bus side and pins of the parallel port block
`timescale 1ns/10ps
`include "mpio_consts.vh"
module mpio_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire [7:0] p1_i,
  input wire [2:0] p2_oe,
  input wire [3:0] p3_oe,
  input wire [7:0] p6_oe,
  input wire [7:0] p6_analog_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd_set = psel && !penable && !pwrite;
  wire wr_done = psel && penable && pready && pwrite;
  wire [11:0] a = paddr;
  answer_due_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  answer_once_a: assert property (pready |=> !pready)
    else $error("answer held too long");
  pin_sample_a: assert property (rd_set && a == `MPIO_OFF_P1_PIN |=>
    prdata[7:0] == $past(p1_i)) else $error("pin read not sampled at setup");
  pins_hold_a: assert property ($changed({p2_oe, p3_oe, p6_oe}) && $past(presetn, 3) |->
    $past(wr_done) || $past(wr_done, 2)) else $error("pins moved without a write");
  two_upper_a: assert property (pready && !pwrite &&
    (a == `MPIO_OFF_P2_PIN || a == `MPIO_OFF_P2_LAT) |-> prdata[31:3] == '0)
    else $error("port two upper bits set");
  three_upper_a: assert property (pready && !pwrite && a == `MPIO_OFF_P3_PIN |->
    prdata[31:4] == '0) else $error("port three upper bits set");
  analog_read_a: assert property (rd_set && a == `MPIO_OFF_P6_PIN |=>
    (prdata[7:0] & $past(p6_analog_en)) == '0) else $error("analog bit read nonzero");
  analog_drive_a: assert property ((p6_oe & p6_analog_en & $past(p6_analog_en)
    & $past(p6_analog_en, 2)) == '0) else $error("analog bit driven");
  cover property (wr_done && a == `MPIO_OFF_P6_DIR);
  cover property (rd_set && a == `MPIO_OFF_P6_PIN && |p6_analog_en);
  cover property (rd_set && a == `MPIO_OFF_P1_PIN);
endmodule // mpio_props
bind mpio_ports mpio_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .prdata, .pready, .p1_i, .p2_oe, .p3_oe, .p6_oe, .p6_analog_en);

// *** mcu_parallel_io_ports_tb.sv ***
// self-checking bench for the parallel port block
`timescale 1ns/10ps
`include "mpio_consts.vh"
module mcu_parallel_io_ports_tb;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0, er;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rd;
  logic [7:0] seg1_val = '0, seg5_val = '0, seg7_val = '0, lo1 = '0;
  logic [3:0] lo3 = '0;
  logic [2:0] lo2 = '0;
  logic [7:0] lo5 = '0, lo6 = '0, lo7 = '0;
  wire [31:0] prdata;
  wire pready, pslverr, crystal_mode, p20_irq;
  wire [7:0] p1_i, p1_o, p1_oe, p5_i, p5_o, p5_oe, p6_i, p6_o, p6_oe;
  wire [7:0] p7_i, p7_o, p7_oe, p6_analog_en;
  wire [2:0] p2_i, p2_o, p2_oe;
  wire [3:0] p3_i, p3_o, p3_oe;
  int n_fail = 0, n_checks = 0;
  // address, reset value, value written, value read back
  localparam logic [35:0] rows [10] = '{
    {`MPIO_OFF_P1_LAT, 8'hff, 8'h5a, 8'h5a}, {`MPIO_OFF_P2_LAT, 8'h07, 8'hff, 8'h07},
    {`MPIO_OFF_P3_LAT, 8'h0f, 8'hff, 8'h0f}, {`MPIO_OFF_P3_DRV, 8'h00, 8'h03, 8'h03},
    {`MPIO_OFF_P5_LAT, 8'hff, 8'h3c, 8'h3c}, {`MPIO_OFF_P6_DIR, 8'h00, 8'h81, 8'h81},
    {`MPIO_OFF_P6_LAT, 8'h00, 8'h00, 8'h00}, {`MPIO_OFF_P7_LAT, 8'hff, 8'hc3, 8'hc3},
    {`MPIO_OFF_CTRL, 8'h09, 8'h09, 8'h09}, {12'h048, 8'h00, 8'hff, 8'h00}};
  mpio_ports DUT (.*);
  mpio_board #(.W(8)) b1 (.d(p1_o), .e(p1_oe), .lo(lo1), .v(p1_i));
  mpio_board #(.W(3)) b2 (.d(p2_o), .e(p2_oe), .lo(lo2), .v(p2_i));
  mpio_board #(.W(4)) b3 (.d(p3_o), .e(p3_oe), .lo(lo3), .v(p3_i));
  mpio_board #(.W(8)) b5 (.d(p5_o), .e(p5_oe), .lo(lo5), .v(p5_i));
  mpio_board #(.W(8)) b6 (.d(p6_o), .e(p6_oe), .lo(lo6), .v(p6_i));
  mpio_board #(.W(8)) b7 (.d(p7_o), .e(p7_oe), .lo(lo7), .v(p7_i));
  always #5 pclk = ~pclk;
  task automatic wrap_up;
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic hold2;
    repeat (2) @(posedge pclk);
  endtask
  initial begin
    #40000;
    n_fail++;
    wrap_up();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      xfer(0, rows[i][35:24], '0);
      chk(rd, rows[i][23:16]);
      xfer(1, rows[i][35:24], rows[i][15:8]);
      xfer(0, rows[i][35:24], '0);
      chk(rd, rows[i][7:0]);
    end
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    lo1 <= 8'h3c;
    xfer(0, `MPIO_OFF_P1_PIN, '0);
    chk(rd, 8'hc3);
    xfer(1, `MPIO_OFF_P1_LAT, 8'h0f);
    xfer(1, `MPIO_OFF_P1_PIN, 8'hff);
    xfer(0, `MPIO_OFF_P1_PIN, '0);
    chk(rd, 8'h03);
    seg1_val <= 8'h80;
    seg5_val <= 8'ha5;
    xfer(1, `MPIO_OFF_P1_SEG, 8'h81);
    xfer(1, `MPIO_OFF_P5_SEG, 8'hff);
    xfer(1, `MPIO_OFF_P7_LAT, 8'h0f);
    xfer(1, `MPIO_OFF_P3_LAT, 8'h05);
    hold2();
    chk({p1_o, p1_oe, p5_o, p5_oe}, 32'h80f1a5ff);
    chk({p7_o, p7_oe, p3_o, p3_oe}, 24'h00f00a);
    xfer(1, `MPIO_OFF_P3_DRV, 8'h0f);
    hold2();
    chk({p3_o, p3_oe}, 8'h5f);
    xfer(1, `MPIO_OFF_P3_LAT, 8'h0f);
    xfer(1, `MPIO_OFF_P3_DRV, 8'h00);
    lo3 <= 4'h6;
    xfer(0, `MPIO_OFF_P3_PIN, '0);
    chk(rd, 8'h09);
    xfer(1, `MPIO_OFF_CTRL, 8'h01);
    xfer(1, `MPIO_OFF_P6_LAT, 8'h0f);
    xfer(0, `MPIO_OFF_P6_PIN, '0);
    chk(rd, 8'h0f);
    xfer(1, `MPIO_OFF_P6_DIR, 8'h30);
    hold2();
    chk({p6_analog_en, p6_o, p6_oe}, 24'hc00f30);
    xfer(1, `MPIO_OFF_P2_LAT, 8'h00);
    xfer(1, `MPIO_OFF_CTRL, 8'h03);
    hold2();
    chk({crystal_mode, p2_oe}, 4'h9);
    xfer(1, `MPIO_OFF_CTRL, 8'h05);
    hold2();
    chk({crystal_mode, p2_oe}, 4'h6);
    xfer(1, `MPIO_OFF_P2_LAT, 8'h07);
    xfer(1, `MPIO_OFF_CTRL, 12'h101);
    hold2();
    chk(p20_irq, 1'b0);
    xfer(1, `MPIO_OFF_P2_LAT, 8'h06);
    repeat (3) @(posedge pclk);
    chk(p20_irq, 1'b1);
    xfer(0, 12'h048, '0);
    chk(er, 1'b1);
    wrap_up();
  end
endmodule // mcu_parallel_io_ports_tb
